// ==== include/epv_pkg.sv ====
// package: constants and carriers for exception priority and vectoring
// Notes on behaviour
// - software sets one of eight levels for seven system handlers, 27 irqs
// - every settable priority field resets to level zero
// - settable level zero ranks below reset, nmi and hard fault
// - equal level ties go to the lowest vector position
// - position 0 holds the stack top, loaded on reset
// - reset is position 1, priority -3, drops to base level after start
// - nmi is position 2, priority -2, preempted only by reset
// - nmi is raised only by a software write to the control register
// - hard fault is position 3, priority -1, escalation of blocked faults
// - memory management is position 4, settable, on protection mismatch
// - bus fault is position 5, settable, can be enabled or disabled
// - usage fault is position 6, settable, undefined or illegal state
// - supervisor call is position 11, settable, from the call instruction
// - debug monitor is position 12, only when enabled and not halting
// - pendable service request is position 14, pended only by software
// - system tick is position 15, raised when the tick timer fires
// - peripheral irqs sit at 16 and above, gated by set-enable bits
// - irq bits: ports a-e, two uarts, serial port, 8 reserved, pwm
// - entry stacks state while fetching vector; exit restores state
// - back to back pending irq is tail-chained without restacking
// - levels split into preemption group and subpriority
package epv_pkg;
  localparam int NUM_IRQ     = 27;
  localparam int NUM_VEC     = 16 + NUM_IRQ;
  localparam int VEC_W       = 6;
  localparam int PRI_W       = 3;
  localparam int RANK_W      = 4;
  // fixed positions
  localparam logic [VEC_W-1:0] VEC_STACK = 6'h00;
  localparam logic [VEC_W-1:0] VEC_RESET = 6'h01;
  localparam logic [VEC_W-1:0] VEC_NMI   = 6'h02;
  localparam logic [VEC_W-1:0] VEC_HARD  = 6'h03;
  localparam logic [VEC_W-1:0] VEC_MEM   = 6'h04;
  localparam logic [VEC_W-1:0] VEC_BUS   = 6'h05;
  localparam logic [VEC_W-1:0] VEC_USAGE = 6'h06;
  localparam logic [VEC_W-1:0] VEC_SVC   = 6'h0b;
  localparam logic [VEC_W-1:0] VEC_DBG   = 6'h0c;
  localparam logic [VEC_W-1:0] VEC_PSR   = 6'h0e;
  localparam logic [VEC_W-1:0] VEC_TICK  = 6'h0f;
  localparam logic [VEC_W-1:0] VEC_IRQ0  = 6'h10;
  // ranks: 0 reset, 1 nmi, 2 hard fault, 3+level settable, 15 base
  localparam logic [RANK_W-1:0] RANK_RESET = 4'h0;
  localparam logic [RANK_W-1:0] RANK_NMI   = 4'h1;
  localparam logic [RANK_W-1:0] RANK_HARD  = 4'h2;
  localparam logic [RANK_W-1:0] RANK_SET0  = 4'h3;
  localparam logic [RANK_W-1:0] RANK_BASE  = 4'hf;
  localparam logic [RANK_W-1:0] RANK_NONE  = 4'hf;
  localparam logic [PRI_W-1:0]  PRI_RESET  = 3'h0;
  localparam logic [NUM_IRQ-1:0] IRQ_RSVD_MASK = 27'h0000100; // bit 8
  // irq bit assignments
  localparam int IRQ_PORT_A = 0;
  localparam int IRQ_UART0  = 5;
  localparam int IRQ_SERIAL = 7;
  localparam int IRQ_PWMF   = 9;
  localparam int IRQ_PWMG0  = 10;
  // cycles spent stacking and unstacking eight words
  localparam logic [3:0] STACK_CYCLES = 4'h8;
  localparam logic [3:0] CNT_RESET    = 4'h0;

  typedef enum logic [2:0] {
    EPV_RESET   = 3'b000,
    EPV_THREAD  = 3'b001,
    EPV_STACK   = 3'b010,
    EPV_HANDLER = 3'b011,
    EPV_UNSTACK = 3'b100
  } epv_state_type;

  // fault and system event inputs
  typedef struct packed {
    logic mem_fault;
    logic bus_fault;
    logic usage_fault;
    logic svc_call;
    logic debug_event;
    logic tick_fire;
  } epv_sys_evt_type;

  // software controls
  typedef struct packed {
    logic [6:0][PRI_W-1:0]       sys_pri;
    logic [NUM_IRQ-1:0][PRI_W-1:0] irq_pri;
    logic [NUM_IRQ-1:0]          irq_enable;
    logic                        bus_fault_en;
    logic                        mem_fault_en;
    logic                        usage_fault_en;
    logic                        debug_mon_en;
    logic                        halted;
    logic [PRI_W-1:0]            sub_bits;
    logic                        set_nmi;
    logic                        set_pend_sv;
  } epv_ctrl_type;

  // core side handshake
  typedef struct packed {
    logic             entry_req;
    logic             stacking;
    logic             unstacking;
    logic             tail_chain;
    logic [VEC_W-1:0] vector;
    logic [RANK_W-1:0] active_rank;
    logic             handler_mode;
    logic             load_stack_top;
  } epv_core_type;
endpackage

// ==== rtl/epv_arbiter.sv ====
// module: lowest-rank then lowest-position winner over all positions
`timescale 1ns/10ps
module epv_arbiter (
  // candidates
  input  wire logic [epv_pkg::NUM_VEC-1:0]                       pend,
  input  wire logic [epv_pkg::NUM_VEC-1:0][epv_pkg::RANK_W-1:0] rank,
  // winner
  output logic                                                   found,
  output logic [epv_pkg::VEC_W-1:0]                              win_vec,
  output logic [epv_pkg::RANK_W-1:0]                             win_rank
);
  import epv_pkg::*;

  // strict compare keeps lowest position on equal rank
  always_comb begin
    found    = 1'b0;
    win_vec  = VEC_STACK;
    win_rank = RANK_NONE;
    for (int i = 0; i < NUM_VEC; i++) begin
      if (pend[i] && (!found || rank[i] < win_rank)) begin
        found    = 1'b1;
        win_vec  = VEC_W'(i);
        win_rank = rank[i];
      end
    end
  end
endmodule // epv_arbiter

// ==== rtl/epv_core.sv ====
// module: exception prioritisation, pending state and entry sequencing
`timescale 1ns/10ps
module epv_core (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // sources
  input  wire logic [epv_pkg::NUM_IRQ-1:0] irq_in,
  input  wire epv_pkg::epv_sys_evt_type    sys_evt,
  // software controls
  input  wire epv_pkg::epv_ctrl_type       ctrl,
  // handler return from core
  input  wire logic                     handler_return,
  // core side
  output epv_pkg::epv_core_type         core,
  output logic [epv_pkg::NUM_VEC-1:0]   pending
);
  import epv_pkg::*;

  typedef struct packed {
    epv_state_type      state;
    logic [3:0]         cnt;
    logic [NUM_VEC-1:0] pend;
    logic [VEC_W-1:0]   act_vec;
    logic [RANK_W-1:0]  act_rank;
    logic [RANK_W-1:0]  prev_rank;
    logic               nested;
    logic               chain;
    logic               stack_top;
  } epv_st_type;

  epv_st_type st_reg;
  epv_st_type st_next;

  logic [NUM_VEC-1:0][RANK_W-1:0] rank;
  logic                           found;
  logic [VEC_W-1:0]               win_vec;
  logic [RANK_W-1:0]              win_rank;

  // settable level to rank, below the three fixed ones
  function automatic logic [RANK_W-1:0] lvl_rank(
      input logic [PRI_W-1:0] lvl);
    lvl_rank = RANK_SET0 + RANK_W'(lvl);
  endfunction

  // preemption group: subpriority bits cleared
  function automatic logic [RANK_W-1:0] group_of(
      input logic [RANK_W-1:0] r, input logic [PRI_W-1:0] sb);
    logic [RANK_W-1:0] m;
    m = RANK_W'(4'hf << sb);
    if (r < RANK_SET0)
      group_of = r;
    else
      group_of = RANK_SET0 + ((r - RANK_SET0) & m);
  endfunction

  // rank of each position
  always_comb begin
    rank = '{default: RANK_NONE};
    rank[VEC_RESET] = RANK_RESET;
    rank[VEC_NMI]   = RANK_NMI;
    rank[VEC_HARD]  = RANK_HARD;
    rank[VEC_MEM]   = lvl_rank(ctrl.sys_pri[0]);
    rank[VEC_BUS]   = lvl_rank(ctrl.sys_pri[1]);
    rank[VEC_USAGE] = lvl_rank(ctrl.sys_pri[2]);
    rank[VEC_SVC]   = lvl_rank(ctrl.sys_pri[3]);
    rank[VEC_DBG]   = lvl_rank(ctrl.sys_pri[4]);
    rank[VEC_PSR]   = lvl_rank(ctrl.sys_pri[5]);
    rank[VEC_TICK]  = lvl_rank(ctrl.sys_pri[6]);
    for (int i = 0; i < NUM_IRQ; i++)
      rank[16 + i] = lvl_rank(ctrl.irq_pri[i]);
  end

  epv_arbiter u_arb (
    .pend     (st_reg.pend),
    .rank     (rank),
    .found    (found),
    .win_vec  (win_vec),
    .win_rank (win_rank)
  );

  // next state
  always_comb begin
    logic [RANK_W-1:0] cur_grp;
    logic              preempt;
    logic              blocked;
    logic [NUM_VEC-1:0] set_vec;
    st_next = st_reg;
    set_vec = '0;
    cur_grp = group_of(st_reg.act_rank, ctrl.sub_bits);
    // only strictly more urgent groups preempt
    preempt = found && (group_of(win_rank, ctrl.sub_bits) < cur_grp);
    blocked = 1'b0;
    // collect this cycle's new requests on their own first
    st_next.pend = '0;
    // configurable faults: escalate to hard fault when blocked or off
    if (sys_evt.mem_fault) begin
      if (!ctrl.mem_fault_en || rank[VEC_MEM] >= st_reg.act_rank)
        blocked = 1'b1;
      else
        st_next.pend[VEC_MEM] = 1'b1;
    end
    if (sys_evt.bus_fault) begin
      if (!ctrl.bus_fault_en || rank[VEC_BUS] >= st_reg.act_rank)
        blocked = 1'b1;
      else
        st_next.pend[VEC_BUS] = 1'b1;
    end
    if (sys_evt.usage_fault) begin
      if (!ctrl.usage_fault_en || rank[VEC_USAGE] >= st_reg.act_rank)
        blocked = 1'b1;
      else
        st_next.pend[VEC_USAGE] = 1'b1;
    end
    if (blocked)
      st_next.pend[VEC_HARD] = 1'b1;
    if (sys_evt.svc_call)
      st_next.pend[VEC_SVC] = 1'b1;
    // debug monitor ignored when off, halting or lower than active
    if (sys_evt.debug_event && ctrl.debug_mon_en && !ctrl.halted &&
        rank[VEC_DBG] < st_reg.act_rank)
      st_next.pend[VEC_DBG] = 1'b1;
    if (ctrl.set_pend_sv)
      st_next.pend[VEC_PSR] = 1'b1;
    if (sys_evt.tick_fire)
      st_next.pend[VEC_TICK] = 1'b1;
    if (ctrl.set_nmi)
      st_next.pend[VEC_NMI] = 1'b1;
    // enabled irqs latch pending; reserved bit never pends
    for (int i = 0; i < NUM_IRQ; i++)
      if (irq_in[i] && ctrl.irq_enable[i] && !IRQ_RSVD_MASK[i])
        st_next.pend[16 + i] = 1'b1;
    // fresh sets kept apart so a set beats an acceptance clear
    set_vec      = st_next.pend;
    st_next.pend = st_reg.pend | set_vec;
    st_next.stack_top = 1'b0;
    case (st_reg.state)
      EPV_RESET: begin
        // stack top loaded in the same cycle that reset drops to base level
        st_next.stack_top = 1'b1;
        st_next.act_vec   = VEC_RESET;
        st_next.act_rank  = RANK_BASE;
        st_next.state     = EPV_THREAD;
      end
      EPV_THREAD: begin
        if (preempt) begin
          st_next.prev_rank       = st_reg.act_rank;
          st_next.nested          = 1'b0;
          st_next.act_vec         = win_vec;
          st_next.act_rank        = win_rank;
          st_next.pend[win_vec]   = 1'b0;
          st_next.cnt             = CNT_RESET;
          st_next.chain           = 1'b0;
          st_next.state           = EPV_STACK;
        end
      end
      EPV_STACK: begin
        // vector presented during stacking
        st_next.cnt = st_reg.cnt + 4'h1;
        if (st_reg.cnt == STACK_CYCLES - 4'h1)
          st_next.state = EPV_HANDLER;
      end
      EPV_HANDLER: begin
        st_next.chain = 1'b0;
        if (preempt) begin
          // nested entry: stack again above current handler
          st_next.prev_rank     = st_reg.act_rank;
          st_next.nested        = 1'b1;
          st_next.act_vec       = win_vec;
          st_next.act_rank      = win_rank;
          st_next.pend[win_vec] = 1'b0;
          st_next.cnt           = CNT_RESET;
          st_next.state         = EPV_STACK;
        end else if (handler_return) begin
          if (found && group_of(win_rank, ctrl.sub_bits) <
              group_of(st_reg.prev_rank, ctrl.sub_bits)) begin
            // tail chain: next handler without unstack and restack
            st_next.act_vec       = win_vec;
            st_next.act_rank      = win_rank;
            st_next.pend[win_vec] = 1'b0;
            st_next.chain         = 1'b1;
          end else begin
            st_next.cnt   = CNT_RESET;
            st_next.state = EPV_UNSTACK;
          end
        end
      end
      EPV_UNSTACK: begin
        st_next.cnt = st_reg.cnt + 4'h1;
        if (st_reg.cnt == STACK_CYCLES - 4'h1) begin
          // single-level return model: back to saved level
          st_next.act_rank = st_reg.nested ? st_reg.prev_rank : RANK_BASE;
          st_next.nested   = 1'b0;
          st_next.state    = st_reg.nested ? EPV_HANDLER : EPV_THREAD;
        end
      end
      default: st_next.state = EPV_RESET;
    endcase
    // a request landing in its own acceptance cycle stays pending
    st_next.pend = st_next.pend | set_vec;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.state     <= EPV_RESET;
      st_reg.cnt       <= CNT_RESET;
      st_reg.pend      <= '0;
      st_reg.act_vec   <= VEC_RESET;
      st_reg.act_rank  <= RANK_RESET;
      st_reg.prev_rank <= RANK_BASE;
      st_reg.nested    <= 1'b0;
      st_reg.chain     <= 1'b0;
      st_reg.stack_top <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // core side outputs
  always_comb begin
    core.entry_req      = (st_reg.state == EPV_STACK) && (st_reg.cnt == 4'h0);
    core.stacking       = st_reg.state == EPV_STACK;
    core.unstacking     = st_reg.state == EPV_UNSTACK;
    core.tail_chain     = st_reg.chain;
    core.vector         = st_reg.act_vec;
    core.active_rank    = st_reg.act_rank;
    core.handler_mode   = (st_reg.state == EPV_HANDLER) ||
                          (st_reg.state == EPV_STACK);
    core.load_stack_top = st_reg.stack_top;
    pending             = st_reg.pend;
  end
endmodule // epv_core

// ==== tb/epv_core_chk.sv ====
// checker: timing relations on the exception sequencer ports
`timescale 1ns/10ps
module epv_core_chk (
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  // sources and controls
  input wire logic [epv_pkg::NUM_IRQ-1:0] irq_in,
  input wire epv_pkg::epv_sys_evt_type    sys_evt,
  input wire epv_pkg::epv_ctrl_type       ctrl,
  input wire logic                       handler_return,
  // core side
  input wire epv_pkg::epv_core_type       core,
  input wire logic [epv_pkg::NUM_VEC-1:0] pending
);
  import epv_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // stacking and unstacking run eight cycles
  sequence s_stack8;
    core.stacking [*8] ##1 (!core.stacking && core.handler_mode);
  endsequence
  sequence s_unstack8;
    core.unstacking [*8] ##1 !core.unstacking;
  endsequence
  a_stack_len: assert property ($rose(core.stacking) |-> s_stack8)
    else $error("stacking length wrong");
  a_unstack_len: assert property ($rose(core.unstacking) |-> s_unstack8)
    else $error("unstacking length wrong");
  a_entry_pulse: assert property (core.entry_req |-> core.stacking ##1 !core.entry_req)
    else $error("entry pulse wrong");
  a_ret_exit: assert property (handler_return |=> core.unstacking || core.tail_chain)
    else $error("return not followed by exit");
  a_tail_nostk: assert property (core.tail_chain |-> !core.unstacking && !core.stacking)
    else $error("tail chain restacked");
  a_irq_pend: assert property (irq_in[0] && ctrl.irq_enable[0] |=> pending[16])
    else $error("irq not pended");
  a_rsvd_bit: assert property (!pending[24])
    else $error("reserved irq pended");
  a_nmi_soft: assert property ($rose(pending[2]) |-> $past(ctrl.set_nmi))
    else $error("nmi without software");
  a_psr_soft: assert property ($rose(pending[14]) |-> $past(ctrl.set_pend_sv))
    else $error("service request without software");
  a_fault_esc: assert property (sys_evt.bus_fault && !ctrl.bus_fault_en |=> pending[3])
    else $error("disabled fault not escalated");
  a_stack_top: assert property ($rose(rst_n) |-> ##[0:1] core.load_stack_top)
    else $error("stack top not loaded");
endmodule // epv_core_chk
bind epv_core epv_core_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .irq_in(irq_in), .sys_evt(sys_evt), .ctrl(ctrl),
  .handler_return(handler_return), .core(core), .pending(pending));

// ==== tb/epv_ret_model.sv ====
// model: core side that returns from each handler after a set hold
`timescale 1ns/10ps
module epv_ret_model (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // core side from the block
  input  wire epv_pkg::epv_core_type core,
  input  wire logic [7:0]           hold,
  // return pulse to the block
  output logic                      handler_return
);
  import epv_pkg::*;
  logic [7:0] cnt;
  // count handler cycles, restart on entry, chain and exit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt            <= 8'h00;
      handler_return <= 1'b0;
    end else begin
      handler_return <= 1'b0;
      if (!core.handler_mode || core.stacking || core.unstacking ||
          core.tail_chain || handler_return) begin
        cnt <= 8'h00;
      end else if (cnt == hold) begin
        handler_return <= 1'b1; // once per handler
        cnt            <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule // epv_ret_model

// ==== tb/exception_priority_vectoring_tb.sv ====
// testbench: entry, priority, tie and chaining scenarios
`timescale 1ns/10ps
module exception_priority_vectoring_tb;
  import epv_pkg::*;
  logic                 sys_clk, rst_n, handler_return;
  logic [NUM_IRQ-1:0]   irq_in;
  epv_sys_evt_type      sys_evt;
  epv_ctrl_type         ctrl;
  epv_core_type         core;
  logic [NUM_VEC-1:0]   pending;
  logic [7:0]           hold;
  int                   error_cnt, total_checks, cycles;
  logic [5:0]           vecs [7] = '{VEC_MEM, VEC_BUS, VEC_USAGE, VEC_SVC,
                                     VEC_DBG, VEC_TICK, VEC_PSR};
  // block and core side model
  epv_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .irq_in(irq_in),
    .sys_evt(sys_evt), .ctrl(ctrl), .handler_return(handler_return),
    .core(core), .pending(pending));
  epv_ret_model u_ret (.sys_clk(sys_clk), .rst_n(rst_n), .core(core),
    .hold(hold), .handler_return(handler_return));
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // wait for an entry or chain, then judge the handler taken
  task automatic expect_entry(input logic [5:0] v, input logic [3:0] r,
                              input logic tc);
    int   n;
    logic seen;
    n = 0;
    while (!(core.entry_req || core.tail_chain) && n < 200) begin
      tick;
      n++;
    end
    seen = core.tail_chain;
    n = 0;
    while (core.stacking !== 1'b0 && n < 20) begin
      tick;
      n++;
    end
    chk("tail_chain", {7'h00, tc}, {7'h00, seen});
    chk("handler_mode", 8'h01, {7'h00, core.handler_mode});
    chk("vector", {2'h0, v}, {2'h0, core.vector});
    if (r !== RANK_NONE) chk("rank", {4'h0, r}, {4'h0, core.active_rank});
  endtask
  task automatic wait_thread;
    int n;
    n = 0;
    while (!(core.active_rank === RANK_BASE && core.handler_mode === 1'b0)
           && n < 200) begin
      tick;
      n++;
    end
    chk("thread rank", {4'h0, RANK_BASE}, {4'h0, core.active_rank});
  endtask
  task automatic pulse_irq(input int b);
    irq_in[b] = 1'b1;
    tick;
    irq_in = '0;
  endtask
  task t_reset;
    chk("reset vector", {2'h0, VEC_RESET}, {2'h0, core.vector});
    chk("reset rank", {4'h0, RANK_RESET}, {4'h0, core.active_rank});
    rst_n = 1'b1;
    repeat (3) tick;
    chk("base rank", {4'h0, RANK_BASE}, {4'h0, core.active_rank});
    $display("t_reset done");
  endtask
  task t_irq0;
    pulse_irq(IRQ_PORT_A);
    expect_entry(VEC_IRQ0, RANK_SET0, 1'b0);
    wait_thread;
    $display("t_irq0 done");
  endtask
  task t_tie;
    ctrl.irq_pri[0] = 3'h1;
    ctrl.irq_pri[1] = 3'h1;
    irq_in = 27'h0000003;
    tick;
    irq_in = '0;
    expect_entry(VEC_IRQ0, RANK_SET0 + 4'h1, 1'b0);
    expect_entry(VEC_IRQ0 + 6'h01, RANK_SET0 + 4'h1, 1'b1);
    wait_thread;
    $display("t_tie done");
  endtask
  task t_group;
    ctrl.sub_bits = 3'h1;
    ctrl.irq_pri[0] = 3'h3;
    ctrl.irq_pri[1] = 3'h2;
    hold = 8'h28;
    pulse_irq(0);
    expect_entry(VEC_IRQ0, RANK_SET0 + 4'h3, 1'b0);
    pulse_irq(1);
    repeat (10) tick;
    chk("held vector", {2'h0, VEC_IRQ0}, {2'h0, core.vector});
    chk("held pending", 8'h01, {7'h00, pending[17]});
    expect_entry(VEC_IRQ0 + 6'h01, RANK_SET0 + 4'h2, 1'b1);
    ctrl.sub_bits = 3'h0;
    ctrl.irq_pri = '0;
    hold = 8'h02;
    wait_thread;
    $display("t_group done");
  endtask
  // nmi preempts a running handler, then the outer level resumes
  task automatic t_nest;
    int n;
    n = 0;
    ctrl.irq_pri[0] = 3'h3;
    hold = 8'h28;
    pulse_irq(IRQ_PORT_A);
    expect_entry(VEC_IRQ0, RANK_SET0 + 4'h3, 1'b0);
    ctrl.set_nmi = 1'b1;
    tick;
    ctrl.set_nmi = 1'b0;
    expect_entry(VEC_NMI, RANK_NMI, 1'b0);
    hold = 8'h02;
    while (core.unstacking !== 1'b1 && n < 200) begin
      tick;
      n++;
    end
    while (core.unstacking === 1'b1 && n < 200) begin
      tick;
      n++;
    end
    chk("resumed rank", {4'h0, RANK_SET0 + 4'h3},
        {4'h0, core.active_rank});
    ctrl.irq_pri = '0;
    wait_thread;
    $display("t_nest done");
  endtask
  task t_nmi;
    ctrl.set_nmi = 1'b1;
    tick;
    ctrl.set_nmi = 1'b0;
    expect_entry(VEC_NMI, RANK_NMI, 1'b0);
    wait_thread;
    $display("t_nmi done");
  endtask
  task t_sys;
    for (int k = 0; k < 7; k++) begin
      if (k == 6) ctrl.set_pend_sv = 1'b1;
      else sys_evt = epv_sys_evt_type'(6'h20 >> k);
      tick;
      sys_evt = '0;
      ctrl.set_pend_sv = 1'b0;
      expect_entry(vecs[k], RANK_SET0, 1'b0);
      wait_thread;
    end
    ctrl.bus_fault_en = 1'b0;
    sys_evt.bus_fault = 1'b1;
    tick;
    sys_evt = '0;
    expect_entry(VEC_HARD, RANK_HARD, 1'b0);
    ctrl.bus_fault_en = 1'b1;
    wait_thread;
    $display("t_sys done");
  endtask
  task t_drop;
    ctrl.halted = 1'b1;
    sys_evt.debug_event = 1'b1;
    tick;
    sys_evt = '0;
    pulse_irq(8);
    repeat (12) tick;
    chk("debug pending", 8'h00, {7'h00, pending[12]});
    chk("idle rank", {4'h0, RANK_BASE}, {4'h0, core.active_rank});
    ctrl.halted = 1'b0;
    $display("t_drop done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    irq_in = '0;
    sys_evt = '0;
    ctrl = '0;
    ctrl.irq_enable = '1;
    ctrl.bus_fault_en = 1'b1;
    ctrl.mem_fault_en = 1'b1;
    ctrl.usage_fault_en = 1'b1;
    ctrl.debug_mon_en = 1'b1;
    hold = 8'h02;
    repeat (6) tick;
    t_reset;
    t_irq0;
    t_tie;
    t_group;
    t_nest;
    t_nmi;
    t_sys;
    t_drop;
    finish_test;
  end
endmodule // exception_priority_vectoring_tb
